/* src/sctmo_top.sv */
// Purpose: smart-card timeout checks, interrupt enables and limits
// Assumes: aclk 100 MHz; card clock and card detect come from outside
// Notes:   one ETU is etu_divisor card clocks
`timescale 1ns/10ps
`include "sctmo_consts.svh"

module sctmo_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic card_clk,
    input wire logic card_detect,
    input wire sctmo_pkg::sctmo_evt_t evt,
    input wire logic [15:0] etu_divisor,
    output logic card_reset_active,
    output logic teardown_active,
    output logic irq
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0] card_irq_enable;
    logic [31:0] timeout_check_enable;
    logic [31:0] card_reset_length;
    logic [31:0] answer_min_delay;
    logic [31:0] answer_max_delay;
    logic [31:0] answer_max_length;
    logic [31:0] work_wait_limit;
    logic [31:0] char_wait_limit;
    logic [31:0] block_wait_limit;
    logic [31:0] block_guard_limit;
    logic [31:0] deactivation_delay;
    logic [31:0] status;
    logic [31:0] next_status;
    sctmo_pkg::sctmo_seq_t seq;

    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [1:0] cd_sync;
    logic [1:0] ck_sync;
    logic cd_prev;
    logic ck_prev;
    logic cd_rise;
    logic cd_fall;
    logic ck_tick;

    // the block debounces nothing, so every glitch that aclk samples is an event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cd_sync <= 2'h0;
            ck_sync <= 2'h0;
            cd_prev <= 1'b0;
            ck_prev <= 1'b0;
        end else begin
            cd_sync <= {cd_sync[0], card_detect};
            ck_sync <= {ck_sync[0], card_clk};
            cd_prev <= cd_sync[1];
            ck_prev <= ck_sync[1];
        end
    end
    assign cd_rise = cd_sync[1] & ~cd_prev;
    assign cd_fall = ~cd_sync[1] & cd_prev;
    assign ck_tick = ck_sync[1] & ~ck_prev;

    // ------------------------------------------------------------------
    // ETU tick from card clocks
    // ------------------------------------------------------------------
    logic [15:0] etu_cnt;
    logic etu_tick;
    assign etu_tick = ck_tick && (etu_cnt + 16'h0001 >= etu_divisor);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            etu_cnt <= 16'h0000;
        end else if (etu_tick) begin
            etu_cnt <= 16'h0000;
        end else if (ck_tick) begin
            etu_cnt <= etu_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic [31:0] wmask;
    logic wr_hit;
    logic cmd_rst;
    logic cmd_deac;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign wr_go = aw_held & w_held & ~s_axi_bvalid;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                    {8{w_strb[1]}}, {8{w_strb[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_comb begin
        case (aw_addr)
            `SCTMO_OFS_IRQ_EN, `SCTMO_OFS_TO_EN, `SCTMO_OFS_CARD_RESET_DURATION,
            `SCTMO_OFS_MIN_DLY, `SCTMO_OFS_MAX_DLY, `SCTMO_OFS_MAX_LEN,
            `SCTMO_OFS_WWT, `SCTMO_OFS_CWT, `SCTMO_OFS_BWT,
            `SCTMO_OFS_BGT, `SCTMO_OFS_DEAC, `SCTMO_OFS_CMD: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCTMO_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `SCTMO_RESP_OKAY : `SCTMO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // field widths enforce the documented ranges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_irq_enable <= `SCTMO_RESET_VAL;
            timeout_check_enable <= `SCTMO_RESET_VAL;
            card_reset_length <= `SCTMO_RESET_VAL;
            answer_min_delay <= `SCTMO_RESET_VAL;
            answer_max_delay <= `SCTMO_RESET_VAL;
            answer_max_length <= `SCTMO_RESET_VAL;
            work_wait_limit <= `SCTMO_RESET_VAL;
            char_wait_limit <= `SCTMO_RESET_VAL;
            block_wait_limit <= `SCTMO_RESET_VAL;
            block_guard_limit <= `SCTMO_RESET_VAL;
            deactivation_delay <= `SCTMO_RESET_VAL;
        end else if (wr_go) begin
            case (aw_addr)
                `SCTMO_OFS_IRQ_EN: card_irq_enable <= (card_irq_enable
                    & ~wmask | w_data & wmask) & `SCTMO_IRQ_EN_MASK;
                `SCTMO_OFS_TO_EN: timeout_check_enable <=
                    (timeout_check_enable & ~wmask | w_data & wmask)
                    & `SCTMO_TO_EN_MASK;
                `SCTMO_OFS_CARD_RESET_DURATION: card_reset_length <= (card_reset_length
                    & ~wmask | w_data & wmask) & `SCTMO_MASK16;
                `SCTMO_OFS_MIN_DLY: answer_min_delay <= (answer_min_delay
                    & ~wmask | w_data & wmask) & `SCTMO_MASK18;
                `SCTMO_OFS_MAX_DLY: answer_max_delay <= (answer_max_delay
                    & ~wmask | w_data & wmask) & `SCTMO_MASK18;
                `SCTMO_OFS_MAX_LEN: answer_max_length <= (answer_max_length
                    & ~wmask | w_data & wmask) & `SCTMO_MASK18;
                `SCTMO_OFS_WWT: work_wait_limit <= (work_wait_limit
                    & ~wmask | w_data & wmask) & `SCTMO_MASK22;
                `SCTMO_OFS_CWT: char_wait_limit <= (char_wait_limit
                    & ~wmask | w_data & wmask) & `SCTMO_MASK22;
                `SCTMO_OFS_BWT: block_wait_limit <= (block_wait_limit
                    & ~wmask | w_data & wmask) & `SCTMO_MASK26;
                `SCTMO_OFS_BGT: block_guard_limit <= (block_guard_limit
                    & ~wmask | w_data & wmask) & `SCTMO_MASK22;
                `SCTMO_OFS_DEAC: deactivation_delay <= (deactivation_delay
                    & ~wmask | w_data & wmask) & `SCTMO_MASK22;
                default: begin
                end
            endcase
        end
    end

    assign cmd_rst = wr_go && aw_addr == `SCTMO_OFS_CMD && w_strb[0]
                     && w_data[`SCTMO_CMD_RST];
    assign cmd_deac = wr_go && aw_addr == `SCTMO_OFS_CMD && w_strb[0]
                      && w_data[`SCTMO_CMD_DEAC];

    // ------------------------------------------------------------------
    // reset and deactivation sequencer
    // ------------------------------------------------------------------
    logic [25:0] seq_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq <= sctmo_pkg::SCTMO_IDLE;
            seq_cnt <= 26'h0000000;
        end else begin
            case (seq)
                sctmo_pkg::SCTMO_IDLE: begin
                    seq_cnt <= 26'h0000000;
                    if (cmd_deac) begin
                        seq <= sctmo_pkg::SCTMO_DEACT;
                    end else if (cmd_rst) begin
                        seq <= sctmo_pkg::SCTMO_RESET;
                    end
                end
                sctmo_pkg::SCTMO_RESET: begin
                    if (cd_fall) begin
                        seq <= sctmo_pkg::SCTMO_DEACT;
                        seq_cnt <= 26'h0000000;
                    end else if (seq_cnt >= card_reset_length[25:0]) begin
                        seq <= sctmo_pkg::SCTMO_IDLE;
                    end else if (ck_tick) begin
                        seq_cnt <= seq_cnt + 26'h0000001;
                    end
                end
                sctmo_pkg::SCTMO_DEACT: begin
                    if (seq_cnt >= deactivation_delay[25:0]) begin
                        seq <= sctmo_pkg::SCTMO_IDLE;
                    end else if (etu_tick) begin
                        seq_cnt <= seq_cnt + 26'h0000001;
                    end
                end
                default: seq <= sctmo_pkg::SCTMO_IDLE;
            endcase
        end
    end
    assign card_reset_active = (seq == sctmo_pkg::SCTMO_RESET);
    assign teardown_active = (seq == sctmo_pkg::SCTMO_DEACT);

    // ------------------------------------------------------------------
    // answer-to-reset timing and protocol timeout checks
    // ------------------------------------------------------------------
    logic atr_on;
    logic [17:0] atr_clk_cnt;
    logic [17:0] atr_etu_cnt;
    logic atr_delay_err;
    logic atr_len_err;
    logic [25:0] wait_cnt [4];
    logic [3:0] to_hit;
    logic [25:0] limits [4];
    assign limits[0] = work_wait_limit[25:0];
    assign limits[1] = char_wait_limit[25:0];
    assign limits[2] = block_wait_limit[25:0];
    assign limits[3] = block_guard_limit[25:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            atr_on <= 1'b0;
            atr_clk_cnt <= 18'h00000;
            atr_etu_cnt <= 18'h00000;
        end else if (evt.answer_start) begin
            atr_on <= 1'b1;
            atr_clk_cnt <= 18'h00000;
            atr_etu_cnt <= 18'h00000;
        end else if (evt.answer_done || atr_delay_err || atr_len_err) begin
            atr_on <= 1'b0;
        end else if (atr_on) begin
            if (ck_tick && atr_clk_cnt != 18'h3FFFF) begin
                atr_clk_cnt <= atr_clk_cnt + 18'h00001;
            end
            if (etu_tick && atr_etu_cnt != 18'h3FFFF) begin
                atr_etu_cnt <= atr_etu_cnt + 18'h00001;
            end
        end
    end
    // a character before min delay, max delay passed before the first ETU, or answer too long
    assign atr_delay_err = atr_on && ((evt.char_received
        && atr_clk_cnt < answer_min_delay[17:0])
        || (atr_etu_cnt == 18'h00000
        && atr_clk_cnt > answer_max_delay[17:0]));
    assign atr_len_err = atr_on && atr_etu_cnt > answer_max_length[17:0];

    // counters restart on each character so a stuck card is caught
    for (genvar i = 0; i < 4; i++) begin : g_wait
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                wait_cnt[i] <= 26'h0000000;
            end else if (!timeout_check_enable[i] || evt.char_received
                         || to_hit[i]) begin
                wait_cnt[i] <= 26'h0000000;
            end else if (etu_tick) begin
                wait_cnt[i] <= wait_cnt[i] + 26'h0000001;
            end
        end
        assign to_hit[i] = timeout_check_enable[i]
                           && wait_cnt[i] > limits[i];
    end

    // ------------------------------------------------------------------
    // status flags and interrupt
    // ------------------------------------------------------------------
    logic rd_status;
    always_comb begin
        next_status = status;
        if (rd_status) begin
            // rx data ready survives a status read
            next_status = status & (32'h00000001 << `SCTMO_ST_RXRDY);
        end
        if (evt.rx_data_read) begin
            next_status[`SCTMO_ST_RXRDY] = 1'b0;
        end
        // sets win over clears
        if (evt.rx_data_ready) next_status[`SCTMO_ST_RXRDY] = 1'b1;
        if (evt.rx_count_reached) next_status[`SCTMO_ST_RXREACH] = 1'b1;
        if (evt.tx_sent) next_status[`SCTMO_ST_TXSENT] = 1'b1;
        if (to_hit[`SCTMO_BIT_EN_BGT]) next_status[`SCTMO_ST_BGT] = 1'b1;
        if (to_hit[`SCTMO_BIT_EN_BWT] || atr_delay_err) begin
            next_status[`SCTMO_ST_BWT] = 1'b1;
        end
        if (to_hit[`SCTMO_BIT_EN_CWT] || atr_len_err) begin
            next_status[`SCTMO_ST_CWT] = 1'b1;
        end
        if (to_hit[`SCTMO_BIT_EN_WWT]) begin
            next_status[`SCTMO_ST_WWT] = 1'b1;
        end
        if (evt.repeat_limit_error) begin
            next_status[`SCTMO_ST_PHY] = 1'b1;
        end
        if (cd_fall) next_status[`SCTMO_ST_REMOVED] = 1'b1;
        if (cd_rise) next_status[`SCTMO_ST_INSERTED] = 1'b1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= `SCTMO_RESET_VAL;
        end else begin
            status <= next_status;
        end
    end

    // enable mask covers bits 14..8, 1, 0
    assign irq = timeout_check_enable[`SCTMO_BIT_MST]
                 && |(status & card_irq_enable);

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic rd_hit;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_status = s_axi_arvalid && s_axi_arready
                       && s_axi_araddr == `SCTMO_OFS_STATUS;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `SCTMO_OFS_STATUS: rd_mux = status;
            `SCTMO_OFS_IRQ_EN: rd_mux = card_irq_enable;
            `SCTMO_OFS_TO_EN: rd_mux = timeout_check_enable;
            `SCTMO_OFS_CARD_RESET_DURATION: rd_mux = card_reset_length;
            `SCTMO_OFS_MIN_DLY: rd_mux = answer_min_delay;
            `SCTMO_OFS_MAX_DLY: rd_mux = answer_max_delay;
            `SCTMO_OFS_MAX_LEN: rd_mux = answer_max_length;
            `SCTMO_OFS_WWT: rd_mux = work_wait_limit;
            `SCTMO_OFS_CWT: rd_mux = char_wait_limit;
            `SCTMO_OFS_BWT: rd_mux = block_wait_limit;
            `SCTMO_OFS_BGT: rd_mux = block_guard_limit;
            `SCTMO_OFS_DEAC: rd_mux = deactivation_delay;
            `SCTMO_OFS_CMD: rd_mux = {30'h00000000,
                (seq == sctmo_pkg::SCTMO_DEACT),
                (seq == sctmo_pkg::SCTMO_RESET)} << `SCTMO_CMD_RST;
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SCTMO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `SCTMO_RESP_OKAY : `SCTMO_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : sctmo_top

/* shared/sctmo_consts.svh */
// Purpose: offsets, field positions and reset values for the smart-card
//          timeout and interrupt configuration block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   definitions only
`ifndef SCTMO_CONSTS_SVH
`define SCTMO_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SCTMO_OFS_STATUS 8'h44
`define SCTMO_OFS_IRQ_EN 8'h48
`define SCTMO_OFS_TO_EN 8'h4C
`define SCTMO_OFS_CARD_RESET_DURATION 8'h60
`define SCTMO_OFS_MIN_DLY 8'h64
`define SCTMO_OFS_MAX_DLY 8'h68
`define SCTMO_OFS_MAX_LEN 8'h6C
`define SCTMO_OFS_WWT 8'h70
`define SCTMO_OFS_CWT 8'h74
`define SCTMO_OFS_BWT 8'h78
`define SCTMO_OFS_BGT 8'h7C
`define SCTMO_OFS_DEAC 8'h80
`define SCTMO_OFS_CMD 8'h84

// ----------------------------------------------------------------------
// field masks and positions
// ----------------------------------------------------------------------
`define SCTMO_IRQ_EN_MASK 32'h00007F03
`define SCTMO_TO_EN_MASK 32'h0000008F
`define SCTMO_MASK16 32'h0000FFFF
`define SCTMO_MASK18 32'h0003FFFF
`define SCTMO_MASK22 32'h003FFFFF
`define SCTMO_MASK26 32'h03FFFFFF
`define SCTMO_BIT_MST 7
`define SCTMO_BIT_EN_BGT 3
`define SCTMO_BIT_EN_BWT 2
`define SCTMO_BIT_EN_CWT 1
`define SCTMO_BIT_EN_WWT 0
`define SCTMO_ST_RXREACH 14
`define SCTMO_ST_TXSENT 13
`define SCTMO_ST_BGT 12
`define SCTMO_ST_BWT 11
`define SCTMO_ST_CWT 10
`define SCTMO_ST_WWT 9
`define SCTMO_ST_PHY 8
`define SCTMO_ST_RXRDY 2
`define SCTMO_ST_REMOVED 1
`define SCTMO_ST_INSERTED 0
`define SCTMO_CMD_RST 1
`define SCTMO_CMD_DEAC 2
`define SCTMO_RESET_VAL 32'h00000000
`define SCTMO_ETU_DIV_RST 16'h0174
`define SCTMO_RESP_OKAY 2'h0
`define SCTMO_RESP_SLVERR 2'h2

`endif

/* shared/sctmo_pkg.sv */
// Purpose: types for the smart-card timeout and interrupt block
// Assumes: constants come from sctmo_consts.svh
// Notes:   none
package sctmo_pkg;

    // ------------------------------------------------------------------
    // reset / deactivation sequencer states, gray from IDLE through RESET to DEACT
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCTMO_IDLE = 2'h0,
        SCTMO_RESET = 2'h1,
        SCTMO_DEACT = 2'h3
    } sctmo_seq_t;

    // ------------------------------------------------------------------
    // events from the card-side logic, one-cycle pulses
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rx_count_reached;
        logic tx_sent;
        logic repeat_limit_error;
        logic char_received;
        logic rx_data_ready;
        logic rx_data_read;
        logic answer_start;
        logic answer_done;
    } sctmo_evt_t;

endpackage : sctmo_pkg

/* dv/sctmo_card.sv */
// Purpose: card-side model: card clock and card detect
// Assumes: clock stands low while no session runs
// Notes: detect edges come clean, no bounce is modelled
`timescale 1ns/10ps
module sctmo_card (
    input wire logic run,
    input wire logic present,
    output logic card_clk,
    output logic card_detect
);
    initial card_clk = 1'h0;
    always #62.5 card_clk = run ? ~card_clk : 1'h0;
    assign card_detect = present;
endmodule : sctmo_card

/* dv/sctmo_checker.sv */
// Purpose: port-level assertions for sctmo_top
// Assumes: one clock domain, sync active-low reset
// Notes: hist keeps register-side causes of the last four edges
`timescale 1ns/10ps
module sctmo_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic irq,
    input wire logic card_reset_active,
    input wire logic teardown_active
);
    logic [3:0] hist;
    logic recent;
    always_ff @(posedge aclk) begin
        hist <= {hist[2:0], !aresetn || s_axi_bvalid ||
            (s_axi_arvalid && s_axi_arready)};
    end
    // a write lands on the same edge that its bvalid rises, so bvalid counts too
    assign recent = |hist || s_axi_bvalid;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    irq_reset_a: assert property ($rose(aresetn) |-> !irq)
        else $error("irq high after reset");
    irq_drop_a: assert property ($fell(irq) |-> recent)
        else $error("irq fell without access");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    r_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_refuse_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while busy");
    seq_excl_a: assert property (
        !(card_reset_active && teardown_active))
        else $error("reset and teardown together");
    reset_start_a: assert property (
        $rose(card_reset_active) |-> recent)
        else $error("reset started alone");
    teardown_start_a: assert property (
        $rose(teardown_active) |-> recent || $past(card_reset_active))
        else $error("teardown started alone");
endmodule : sctmo_checker
bind sctmo_top sctmo_checker sctmo_checker_i (.*);

/* dv/sctmo_top_test.sv */
// Purpose: register-level test of sctmo_top
// Assumes: card clock 125 ns, one card clock per ETU
// Notes: fixed waits cover the two-flop card detect sync
`timescale 1ns/10ps
module sctmo_top_test;
    logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, present = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic card_clk, card_detect, card_reset_active, teardown_active;
    logic [15:0] etu_divisor = 16'h1;
    sctmo_pkg::sctmo_evt_t evt = '0;
    int mismatches = 0, check_count = 0, cycles = 0, n;
    logic [7:0] ofs [11] = '{8'h48, 8'h4C, 8'h60, 8'h64, 8'h68, 8'h6C,
        8'h70, 8'h74, 8'h78, 8'h7C, 8'h80};
    logic [31:0] msk [11] = '{32'h7F03, 32'h8F, 32'hFFFF, 32'h3FFFF,
        32'h3FFFF, 32'h3FFFF, 32'h3FFFFF, 32'h3FFFFF, 32'h3FFFFFF,
        32'h3FFFFF, 32'h3FFFFF};
    sctmo_top sctmo_top_i (.*);
    sctmo_card sctmo_card_i (.*);
    always #5 aclk = ~aclk;
    task finish_test;
        if (mismatches == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(posedge aclk);
    endtask : tick
    // one-cycle event, then an idle edge so pulses never collide
    task pulse(input logic [7:0] e);
        evt <= e;
        @(posedge aclk);
        evt <= '0;
        @(posedge aclk);
    endtask : pulse
    // bready waits a cycle after bvalid so the response must stand
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) ad = 1'h1;
            if (s_axi_wvalid && s_axi_wready) wd = 1'h1;
            if (ad) s_axi_awvalid <= 1'h0;
            if (wd) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1) @(posedge aclk);
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge aclk);
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        v = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask : rd
    initial begin
        tick(2);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 11; i++) begin
            rd(ofs[i], d);
            chk(d, 32'h0);
            wr(ofs[i], 32'hFFFFFFFF);
            chk(r, 2'h0);
            rd(ofs[i], d);
            chk(d, msk[i]);
            wr(ofs[i], 32'h0);
        end
        wr(8'h90, 32'h1);
        chk(r, 2'h2);
        present <= 1'h1;
        tick(6);
        rd(8'h44, d);
        chk(d, 32'h1);
        rd(8'h44, d);
        chk(d, 32'h0);
        wr(8'h48, 32'h3);
        present <= 1'h0;
        tick(6);
        chk(irq, 1'h0);
        wr(8'h4C, 32'h80);
        tick(2);
        chk(irq, 1'h1);
        rd(8'h44, d);
        chk(d, 32'h2);
        tick(2);
        chk(irq, 1'h0);
        wr(8'h48, 32'h4000);
        for (int k = 0; k < 3; k++) begin
            pulse(8'h80 >> k);
            tick(1);
            chk(irq, k == 0);
            rd(8'h44, d);
            chk(d, k == 2 ? 32'h100 : 32'h4000 >> k);
        end
        // limit of 2 ETUs keeps each timeout short
        run <= 1'h1;
        for (int i = 6; i < 10; i++) wr(ofs[i], 32'h2);
        for (int i = 0; i < 4; i++) begin
            wr(8'h48, 32'h200 << i);
            wr(8'h4C, 32'h80 | (32'h1 << i));
            tick(100);
            chk(irq, 1'h1);
            wr(8'h4C, 32'h80);
            rd(8'h44, d);
            chk(d, 32'h200 << i);
        end
        // early first character, then an answer longer than 2 ETUs
        wr(8'h6C, 32'h2);
        wr(8'h64, 32'h5);
        pulse(8'h02);
        pulse(8'h10);
        rd(8'h44, d);
        chk(d, 32'h800);
        pulse(8'h02);
        tick(100);
        rd(8'h44, d);
        chk(d, 32'h400);
        // rx data ready outlives status reads until the data is read
        pulse(8'h08);
        rd(8'h44, d);
        chk(d, 32'h4);
        rd(8'h44, d);
        chk(d, 32'h4);
        pulse(8'h04);
        rd(8'h44, d);
        chk(d, 32'h0);
        wr(8'h80, 32'h3);
        wr(8'h60, 32'h4);
        wr(8'h84, 32'h2);
        while (card_reset_active !== 1'h1) @(posedge aclk);
        n = 0;
        while (card_reset_active === 1'h1) begin
            @(posedge aclk);
            n++;
        end
        // four card clocks of 12.5 cycles, up to one card clock less or 4 cycles more
        chk(n >= 37, 1'h1);
        chk(n <= 54, 1'h1);
        rd(8'h84, d);
        chk(d, 32'h0);
        present <= 1'h1;
        tick(6);
        wr(8'h60, 32'hC8);
        wr(8'h84, 32'h2);
        while (card_reset_active !== 1'h1) @(posedge aclk);
        present <= 1'h0;
        while (teardown_active !== 1'h1) @(posedge aclk);
        chk(card_reset_active, 1'h0);
        while (teardown_active === 1'h1) @(posedge aclk);
        rd(8'h84, d);
        chk(d, 32'h0);
        finish_test();
    end
endmodule : sctmo_top_test
